// ---- core/fpmc_datapath_ctrl.sv ----
// micro-operation control of the floating-point datapath, with an AHB-Lite register slave
`timescale 1ns/1ns
`default_nettype none

module fpmc_datapath_ctrl #(
  parameter int unsigned QW = 32
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  input  wire logic        coprocessor_attention,
  output logic             paused,
  output logic             integer_long_flag
);

  // data phase of the current bus transfer
  logic        dph_valid_q;
  logic        dph_write_q;
  logic [7:0]  dph_addr_q;
  logic        wr_en;
  logic        stall;
  logic        uop_go;

  // operands supplied by software
  logic [9:0]  exponent_alu_q;
  logic [2:0]  mul_cnt_q;
  logic        sub_q;
  logic        div_mode_q;
  logic        res_neg_q;
  logic        res_zero_q;
  logic        qbit_q;
  logic [7:0]  frac_top_q;
  logic [2:0]  pad_sign_q;
  logic [31:0] acc_output_mux_q;
  logic [31:0] data_in_mux_q;
  logic [31:0] uop_last_q;

  // datapath control state
  fpmc_pkg::fpmc_state_t state_q;
  logic [1:0]  timer_q;
  logic        il_q;
  logic [31:0] out_buffer_q;
  logic [QW-1:0] qr_q;
  logic [QW-1:0] qr_shifted;
  logic [QW-1:0] qr_filled;
  logic [9:0]  sc_q;
  logic [1:0]  sel_a_q;
  logic [1:0]  sel_bf_q;
  logic        ss_q;
  logic        sd_q;
  logic        fn_q;
  logic        fz_q;
  logic        fv_q;
  logic [2:0]  shc_count_q;
  logic        shc_left_q;
  logic        shc_inh_fr_q;
  logic        shc_inh_qr_q;
  logic        shc_range_q;
  logic [31:0] ubr_q;
  logic        pad_sign;

  // attention pin synchroniser
  logic        att_s1_q;
  logic        att_s2_q;
  logic        att_s3_q;
  logic        att_lvl_q;
  logic        att_rise;

  // micro-operation fields taken from the written word
  logic [4:0]  op_code;
  logic [2:0]  op_arg;
  logic        op_long;
  logic        op_fcc;

  assign op_code = hwdata[fpmc_pkg::UOP_CODE_LSB +: 5];
  assign op_arg  = hwdata[fpmc_pkg::UOP_ARG_LSB +: 3];
  assign op_long = hwdata[fpmc_pkg::UOP_LONG_BIT];
  assign op_fcc  = hwdata[fpmc_pkg::UOP_FCC_BIT];

  // count of left shifts until the top two bits differ
  function automatic logic [2:0] norm_count(input logic [7:0] f);
    logic [2:0] c;
    c = 3'h7;
    for (int i = 6; i >= 0; i--) begin
      if (f[7-i] != f[6-i]) begin
        c = 3'(i);
      end
    end
    return c;
  endfunction

  // ---------------- bus slave ----------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dph_valid_q <= 1'b0;
      dph_write_q <= 1'b0;
      dph_addr_q  <= 8'h00;
    end else if (hready) begin
      dph_valid_q <= hsel & htrans[1];
      dph_write_q <= hwrite;
      dph_addr_q  <= haddr[7:0];
    end
  end

  // a new micro-op waits for the running microstate to end
  assign stall     = dph_valid_q & dph_write_q & (dph_addr_q == fpmc_pkg::OFS_UOP)
                   & (state_q == fpmc_pkg::ST_BUSY);
  assign hreadyout = ~stall;
  assign hresp     = 1'b0;
  assign wr_en     = dph_valid_q & dph_write_q & hreadyout;
  // while paused a micro-op is dropped rather than stalled, so the bus never locks up
  assign uop_go    = wr_en & (dph_addr_q == fpmc_pkg::OFS_UOP) & (state_q == fpmc_pkg::ST_IDLE);

  always_comb begin
    hrdata = 32'h0000_0000;
    if (dph_valid_q && !dph_write_q) begin
      case (dph_addr_q)
        fpmc_pkg::OFS_UOP:      hrdata = uop_last_q;
        fpmc_pkg::OFS_OPERAND:  hrdata = {11'h000, qbit_q, res_zero_q, res_neg_q, div_mode_q, sub_q,
                                          1'b0, mul_cnt_q, 2'h0, exponent_alu_q};
        fpmc_pkg::OFS_FRACTION: hrdata = {21'h000000, pad_sign_q, frac_top_q};
        fpmc_pkg::OFS_ACC_OUT:  hrdata = acc_output_mux_q;
        fpmc_pkg::OFS_DATA_IN:  hrdata = data_in_mux_q;
        fpmc_pkg::OFS_STATUS:   hrdata = {20'h00000, sel_bf_q, sel_a_q, state_q == fpmc_pkg::ST_BUSY,
                                          paused, fv_q, fz_q, fn_q, sd_q, ss_q, il_q};
        fpmc_pkg::OFS_OUT_BUF:  hrdata = out_buffer_q;
        fpmc_pkg::OFS_QUOTIENT: hrdata = 32'(qr_q);
        fpmc_pkg::OFS_SHIFT:    hrdata = {9'h000, shc_range_q, shc_inh_qr_q, shc_inh_fr_q, shc_left_q,
                                          shc_count_q, 6'h00, sc_q};
        fpmc_pkg::OFS_UBREAK:   hrdata = ubr_q;
        default:                hrdata = 32'h0000_0000;
      endcase
    end
  end

  // software-written operand registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      exponent_alu_q     <= 10'h000;
      mul_cnt_q  <= 3'h0;
      sub_q      <= 1'b0;
      div_mode_q <= 1'b0;
      res_neg_q  <= 1'b0;
      res_zero_q <= 1'b0;
      qbit_q     <= 1'b0;
      frac_top_q <= 8'h00;
      pad_sign_q <= 3'h0;
      acc_output_mux_q    <= 32'h0000_0000;
      data_in_mux_q     <= 32'h0000_0000;
      uop_last_q <= 32'h0000_0000;
    end else if (wr_en) begin
      case (dph_addr_q)
        fpmc_pkg::OFS_UOP: begin
          uop_last_q <= hwdata;
        end
        fpmc_pkg::OFS_OPERAND: begin
          exponent_alu_q     <= hwdata[fpmc_pkg::OPD_EXPONENT_ALU_LSB +: 10];
          mul_cnt_q  <= hwdata[fpmc_pkg::OPD_MUL_LSB +: 3];
          sub_q      <= hwdata[fpmc_pkg::OPD_SUB_BIT];
          div_mode_q <= hwdata[fpmc_pkg::OPD_DIV_BIT];
          res_neg_q  <= hwdata[fpmc_pkg::OPD_NEG_BIT];
          res_zero_q <= hwdata[fpmc_pkg::OPD_ZERO_BIT];
          qbit_q     <= hwdata[fpmc_pkg::OPD_QBIT_BIT];
        end
        fpmc_pkg::OFS_FRACTION: begin
          frac_top_q <= hwdata[fpmc_pkg::FRC_TOP_LSB +: 8];
          pad_sign_q <= hwdata[fpmc_pkg::FRC_SGN_LSB +: 3];
        end
        fpmc_pkg::OFS_ACC_OUT: acc_output_mux_q <= hwdata;
        fpmc_pkg::OFS_DATA_IN: data_in_mux_q  <= hwdata;
        default: ;
      endcase
    end
  end

  // ---------------- attention and microstate sequencing ----------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      att_s1_q  <= 1'b0;
      att_s2_q  <= 1'b0;
      att_s3_q  <= 1'b0;
      att_lvl_q <= 1'b0;
    end else begin
      att_s1_q <= coprocessor_attention;
      att_s2_q <= att_s1_q;
      att_s3_q <= att_s2_q;
      if (att_s2_q == att_s3_q) begin
        att_lvl_q <= att_s3_q;
      end
    end
  end

  assign att_rise = (att_s2_q == att_s3_q) & att_s3_q & ~att_lvl_q;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= fpmc_pkg::ST_IDLE;
      timer_q <= 2'h0;
    end else begin
      case (state_q)
        fpmc_pkg::ST_IDLE: begin
          if (uop_go && op_code == fpmc_pkg::OP_WAIT) begin
            state_q <= fpmc_pkg::ST_PAUSE;
          end else if (uop_go) begin
            timer_q <= op_long ? fpmc_pkg::LONG_EXTRA : fpmc_pkg::NORMAL_EXTRA;
            state_q <= fpmc_pkg::ST_BUSY;
          end
        end
        fpmc_pkg::ST_BUSY: begin
          timer_q <= timer_q - 2'h1;
          if (timer_q == 2'h1) begin
            state_q <= fpmc_pkg::ST_IDLE;
          end
        end
        fpmc_pkg::ST_PAUSE: begin
          if (att_rise) begin
            state_q <= fpmc_pkg::ST_IDLE;
          end
        end
        default: state_q <= fpmc_pkg::ST_IDLE;
      endcase
    end
  end

  assign paused            = (state_q == fpmc_pkg::ST_PAUSE);
  assign integer_long_flag = il_q;

  // ---------------- datapath registers ----------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      il_q <= 1'b0;
    end else if (uop_go && op_code == fpmc_pkg::OP_SET_SHORT) begin
      il_q <= 1'b0;
    end else if (uop_go && op_code == fpmc_pkg::OP_SET_LONG) begin
      il_q <= 1'b1;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      out_buffer_q <= 32'h0000_0000;
      ubr_q  <= 32'h0000_0000;
      sc_q   <= 10'h000;
    end else if (uop_go) begin
      if (op_code == fpmc_pkg::OP_OUT_BUFFER_LOAD) begin
        out_buffer_q <= acc_output_mux_q;
      end
      if (op_code == fpmc_pkg::OP_UBR_LOAD) begin
        ubr_q <= data_in_mux_q;
      end
      if (op_code == fpmc_pkg::OP_SC_LOAD) begin
        sc_q <= exponent_alu_q;
      end
    end
  end

  // an out-of-range count empties the register instead of wrapping
  always_comb begin
    if (shc_inh_qr_q) begin
      qr_shifted = qr_q;
    end else if (!shc_range_q) begin
      qr_shifted = '0;
    end else if (shc_left_q) begin
      qr_shifted = qr_q << shc_count_q;
    end else begin
      qr_shifted = qr_q >> shc_count_q;
    end
  end

  // the argument holds the number of ones minus one
  assign qr_filled = (qr_q >> ({1'b0, op_arg} + 4'h1)) | ~({QW{1'b1}} >> ({1'b0, op_arg} + 4'h1));

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      qr_q <= '0;
    end else if (uop_go) begin
      case (op_code)
        fpmc_pkg::OP_QR_CLEAR:  qr_q <= '0;
        fpmc_pkg::OP_ONES_FILL: qr_q <= qr_filled;
        fpmc_pkg::OP_QR_LOAD: begin
          if (op_arg == fpmc_pkg::QMX_SHIFTER) begin
            qr_q <= qr_shifted;
          end else if (op_arg == fpmc_pkg::QMX_QUOTIENT && div_mode_q) begin
            qr_q <= {qr_q[QW-2:0], qbit_q};
          end
        end
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sel_a_q  <= fpmc_pkg::PAD_DEST;
      sel_bf_q <= fpmc_pkg::PAD_DEST;
    end else if (uop_go && op_code == fpmc_pkg::OP_PAD_SEL) begin
      case (op_arg)
        3'h0: begin sel_a_q <= fpmc_pkg::PAD_DEST; sel_bf_q <= fpmc_pkg::PAD_DEST; end
        3'h1: begin sel_a_q <= fpmc_pkg::PAD_DEST; sel_bf_q <= fpmc_pkg::PAD_SRC;  end
        3'h2: begin sel_a_q <= fpmc_pkg::PAD_SRC;  sel_bf_q <= fpmc_pkg::PAD_DEST; end
        3'h3: begin sel_a_q <= fpmc_pkg::PAD_SRC;  sel_bf_q <= fpmc_pkg::PAD_SRC;  end
        3'h4: begin sel_a_q <= fpmc_pkg::PAD_AC6;  sel_bf_q <= fpmc_pkg::PAD_AC6;  end
        default: ;
      endcase
    end
  end

  // the sign travels with the fraction pad
  assign pad_sign = (sel_bf_q == fpmc_pkg::PAD_AC6) ? pad_sign_q[2] : pad_sign_q[sel_bf_q[0]];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ss_q <= 1'b0;
      sd_q <= 1'b0;
    end else if (uop_go) begin
      case (op_code)
        fpmc_pkg::OP_SIGN_CLR: begin
          ss_q <= 1'b0;
          sd_q <= 1'b0;
        end
        fpmc_pkg::OP_SIGN_PAD: begin
          ss_q <= pad_sign;
          sd_q <= pad_sign;
        end
        fpmc_pkg::OP_SD_SCMSB:   sd_q <= sc_q[9];
        fpmc_pkg::OP_SD_SS:      sd_q <= ss_q;
        fpmc_pkg::OP_SD_NSS:     sd_q <= ~ss_q;
        fpmc_pkg::OP_SD_SS_COND: sd_q <= ss_q ^ sub_q;
        fpmc_pkg::OP_SD_XOR:     sd_q <= ss_q ^ sd_q;
        default: ;
      endcase
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fn_q <= 1'b0;
      fz_q <= 1'b0;
      fv_q <= 1'b0;
    end else if (uop_go && op_code == fpmc_pkg::OP_CC_UPDATE) begin
      fn_q <= res_neg_q;
      fz_q <= res_zero_q;
      if (op_fcc) begin
        fv_q <= exponent_alu_q[fpmc_pkg::EXPONENT_ALU_OVF_BIT];
      end
    end
  end

  // ---------------- shift control ----------------

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      shc_count_q  <= 3'h0;
      shc_left_q   <= 1'b0;
      shc_inh_fr_q <= 1'b0;
      shc_inh_qr_q <= 1'b0;
      shc_range_q  <= 1'b1;
    end else if (uop_go) begin
      case (op_code)
        fpmc_pkg::OP_SH_DIV: begin
          shc_count_q  <= norm_count(frac_top_q);
          shc_left_q   <= 1'b1;
          shc_inh_fr_q <= 1'b0;
          shc_inh_qr_q <= 1'b0;
          shc_range_q  <= 1'b1;
        end
        fpmc_pkg::OP_SH_ALIGN: begin
          shc_count_q  <= exponent_alu_q[2:0];
          shc_left_q   <= 1'b0;
          shc_inh_fr_q <= sc_q[9];
          shc_inh_qr_q <= ~sc_q[9];
          shc_range_q  <= 1'b1;
        end
        fpmc_pkg::OP_SH_MUL: begin
          shc_count_q  <= mul_cnt_q;
          shc_left_q   <= 1'b0;
          shc_inh_fr_q <= 1'b0;
          shc_inh_qr_q <= 1'b0;
          shc_range_q  <= 1'b1;
        end
        fpmc_pkg::OP_SH_CLR: begin
          shc_count_q  <= 3'h0;
          shc_range_q  <= 1'b1;
        end
        fpmc_pkg::OP_SH_EXPONENT_ALU: begin
          shc_count_q  <= exponent_alu_q[2:0];
          shc_left_q   <= ~exponent_alu_q[fpmc_pkg::EXPONENT_ALU_DIR_BIT];
          shc_inh_fr_q <= 1'b0;
          shc_inh_qr_q <= 1'b0;
          shc_range_q  <= exponent_alu_q[fpmc_pkg::EXPONENT_ALU_DIR_BIT] ? (exponent_alu_q[5:3] == 3'h7) : (exponent_alu_q[5:3] == 3'h0);
        end
        fpmc_pkg::OP_SH_NORM: begin
          shc_count_q  <= norm_count(frac_top_q);
          shc_left_q   <= 1'b1;
          shc_inh_fr_q <= 1'b0;
          shc_inh_qr_q <= 1'b1;
          shc_range_q  <= 1'b1;
        end
        default: ;
      endcase
    end
  end

endmodule // fpmc_datapath_ctrl

`default_nettype wire

// ---- core/fpmc_pkg.sv ----
// constants, register map and micro-operation codes of the micro-op datapath control
package fpmc_pkg;

  // microstate timing
  localparam int unsigned CLK_PERIOD_NS  = 100;
  localparam int unsigned T_NORMAL_NS    = 180;
  localparam int unsigned T_LONG_NS      = 240;
  localparam int unsigned NORMAL_CYCLES  = (T_NORMAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned LONG_CYCLES    = (T_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0]  NORMAL_EXTRA   = 2'(NORMAL_CYCLES - 1);
  localparam logic [1:0]  LONG_EXTRA     = 2'(LONG_CYCLES - 1);

  // register byte offsets
  localparam logic [7:0] OFS_UOP       = 8'h00;
  localparam logic [7:0] OFS_OPERAND   = 8'h04;
  localparam logic [7:0] OFS_FRACTION  = 8'h08;
  localparam logic [7:0] OFS_ACC_OUT   = 8'h0C;
  localparam logic [7:0] OFS_DATA_IN   = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_OUT_BUF   = 8'h18;
  localparam logic [7:0] OFS_QUOTIENT  = 8'h1C;
  localparam logic [7:0] OFS_SHIFT     = 8'h20;
  localparam logic [7:0] OFS_UBREAK    = 8'h24;

  // micro-operation word fields
  localparam int unsigned UOP_CODE_LSB = 0;
  localparam int unsigned UOP_LONG_BIT = 8;
  localparam int unsigned UOP_ARG_LSB  = 12;
  localparam int unsigned UOP_FCC_BIT  = 15;

  // operand word fields
  localparam int unsigned OPD_EXPONENT_ALU_LSB = 0;
  localparam int unsigned OPD_MUL_LSB  = 12;
  localparam int unsigned OPD_SUB_BIT  = 16;
  localparam int unsigned OPD_DIV_BIT  = 17;
  localparam int unsigned OPD_NEG_BIT  = 18;
  localparam int unsigned OPD_ZERO_BIT = 19;
  localparam int unsigned OPD_QBIT_BIT = 20;
  localparam int unsigned FRC_TOP_LSB  = 0;
  localparam int unsigned FRC_SGN_LSB  = 8;

  // exponent unit bit positions
  localparam int unsigned EXPONENT_ALU_DIR_BIT = 6;
  localparam int unsigned EXPONENT_ALU_OVF_BIT = 8;

  // micro-operation codes
  localparam logic [4:0] OP_NOP         = 5'h00;
  localparam logic [4:0] OP_SET_SHORT   = 5'h01;
  localparam logic [4:0] OP_SET_LONG    = 5'h02;
  localparam logic [4:0] OP_OUT_BUFFER_LOAD   = 5'h03;
  localparam logic [4:0] OP_ONES_FILL   = 5'h04;
  localparam logic [4:0] OP_QR_CLEAR    = 5'h05;
  localparam logic [4:0] OP_QR_LOAD     = 5'h06;
  localparam logic [4:0] OP_SC_LOAD     = 5'h07;
  localparam logic [4:0] OP_PAD_SEL     = 5'h08;
  localparam logic [4:0] OP_SIGN_CLR    = 5'h09;
  localparam logic [4:0] OP_SIGN_PAD    = 5'h0A;
  localparam logic [4:0] OP_SD_SCMSB    = 5'h0B;
  localparam logic [4:0] OP_SD_SS       = 5'h0C;
  localparam logic [4:0] OP_SD_NSS      = 5'h0D;
  localparam logic [4:0] OP_SD_SS_COND  = 5'h0E;
  localparam logic [4:0] OP_SD_XOR      = 5'h0F;
  localparam logic [4:0] OP_CC_UPDATE   = 5'h10;
  localparam logic [4:0] OP_SH_DIV      = 5'h11;
  localparam logic [4:0] OP_SH_ALIGN    = 5'h12;
  localparam logic [4:0] OP_SH_MUL      = 5'h13;
  localparam logic [4:0] OP_SH_CLR      = 5'h14;
  localparam logic [4:0] OP_SH_EXPONENT_ALU     = 5'h15;
  localparam logic [4:0] OP_SH_NORM     = 5'h16;
  localparam logic [4:0] OP_UBR_LOAD    = 5'h17;
  localparam logic [4:0] OP_WAIT        = 5'h18;

  // quotient input mux choices and pad selections
  localparam logic [2:0] QMX_SHIFTER    = 3'h0;
  localparam logic [2:0] QMX_QUOTIENT   = 3'h1;
  localparam logic [1:0] PAD_DEST       = 2'h0;
  localparam logic [1:0] PAD_SRC        = 2'h1;
  localparam logic [1:0] PAD_AC6        = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_BUSY  = 3'b010,
    ST_PAUSE = 3'b100
  } fpmc_state_t;

endpackage

// ---- dv/fpmc_datapath_ctrl_sva.sv ----
// port-level assertions for the micro-op datapath control
`timescale 1ns/1ns
`default_nettype none
module fpmc_datapath_ctrl_sva #(
  parameter int unsigned QW = 32
) (
  input wire logic        hclk,
  input wire logic        hresetn,
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic        hreadyout,
  input wire logic        hresp,
  input wire logic [31:0] hrdata,
  input wire logic        coprocessor_attention,
  input wire logic        paused,
  input wire logic        integer_long_flag
);
  logic uop_dp_q;
  logic st_rd_q;
  logic take_uop;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      uop_dp_q <= 1'b0;
      st_rd_q  <= 1'b0;
    end else if (hready) begin
      uop_dp_q <= hsel && htrans[1] && hwrite && (haddr[7:0] == 8'h00);
      st_rd_q  <= hsel && htrans[1] && !hwrite && (haddr[7:0] == 8'h14);
    end
  end
  // a micro-op only executes when the write completes outside the pause state
  assign take_uop = uop_dp_q && hreadyout && !paused;
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_LONG_SET: assert property (take_uop && hwdata[4:0] == 5'h02 |=> integer_long_flag)
    else $error("long integer flag not set");
  AST_SHORT_SET: assert property (take_uop && hwdata[4:0] == 5'h01 |=> !integer_long_flag)
    else $error("long integer flag not cleared");
  AST_FLAG_HOLD: assert property (!take_uop |=> $stable(integer_long_flag))
    else $error("long integer flag moved without a micro-op");
  AST_STATUS_FLAG: assert property (st_rd_q && hreadyout |-> hrdata[0] == integer_long_flag)
    else $error("status flag bit disagrees with pin");
  AST_STALL_BOUND: assert property (!hreadyout |-> ##[1:2] hreadyout)
    else $error("microstate stall too long");
  AST_STALL_CAUSE: assert property (!hreadyout |-> uop_dp_q)
    else $error("stall outside a micro-op write");
  AST_PAUSE_ENTER: assert property (take_uop && hwdata[4:0] == 5'h18 |=> paused)
    else $error("wait did not pause");
  AST_PAUSE_CAUSE: assert property (!paused && !(take_uop && hwdata[4:0] == 5'h18) |=> !paused)
    else $error("pause entered without wait");
  AST_PAUSE_HOLD: assert property ((!coprocessor_attention)[*4] ##0 paused |=> paused)
    else $error("pause left without attention");
  AST_PAUSE_EXIT: assert property ((!coprocessor_attention)[*4] ##1 (coprocessor_attention && paused)
    |-> ##[1:6] !paused)
    else $error("pause not left after attention");
endmodule // fpmc_datapath_ctrl_sva
bind fpmc_datapath_ctrl fpmc_datapath_ctrl_sva #(.QW(QW)) fpmc_datapath_ctrl_sva_i (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
  .hsize(hsize), .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hresp(hresp),
  .hrdata(hrdata), .coprocessor_attention(coprocessor_attention), .paused(paused),
  .integer_long_flag(integer_long_flag));
`default_nettype wire

// ---- dv/fpmc_datapath_ctrl_tb.sv ----
// self-checking bench for the micro-op datapath control
`timescale 1ns/1ns
`default_nettype none
module fpmc_datapath_ctrl_tb;
  typedef struct packed {
    logic [19:0] opd;
    logic [15:0] uop;
    logic [7:0]  addr;
    logic [31:0] mask;
    logic [31:0] exp;
  } fpmc_step_t;
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] mask;
    logic [31:0] exp;
  } fpmc_note_t;
  logic        hclk = 1'b0;
  logic        hresetn, hsel, hwrite, hready_w, hresp, go, slow, att, paused, il;
  logic [31:0] haddr, hwdata, hrdata, acc;
  logic [1:0]  htrans;
  logic [2:0]  hsize;
  logic        rd_dp = 1'b0;
  int          error_cnt = 0, total_checks = 0, seed = 4121, waits, w_norm, n;
  fpmc_note_t  notes[$];
  fpmc_note_t  nt;
  fpmc_step_t  steps [30] = '{
    '{20'h10200, 16'h0007, 8'h20, 32'h3FF, 32'h200},
    '{20'h10200, 16'h0009, 8'h14, 32'h6, 32'h0},
    '{20'h10200, 16'h000A, 8'h14, 32'h6, 32'h6},
    '{20'h10200, 16'h000D, 8'h14, 32'h6, 32'h2},
    '{20'h10200, 16'h000F, 8'h14, 32'h6, 32'h6},
    '{20'h10200, 16'h000E, 8'h14, 32'h6, 32'h2},
    '{20'h10200, 16'h000C, 8'h14, 32'h6, 32'h6},
    '{20'h10200, 16'h0009, 8'h14, 32'h6, 32'h0},
    '{20'h10200, 16'h000B, 8'h14, 32'h6, 32'h4},
    '{20'h10200, 16'h000C, 8'h14, 32'h6, 32'h0},
    '{20'h10200, 16'h000E, 8'h14, 32'h6, 32'h4},
    '{20'h00000, 16'h1008, 8'h14, 32'hF00, 32'h400},
    '{20'h00000, 16'h2008, 8'h14, 32'hF00, 32'h100},
    '{20'h00000, 16'h3008, 8'h14, 32'hF00, 32'h500},
    '{20'h00000, 16'h4008, 8'h14, 32'hF00, 32'hA00},
    '{20'h40100, 16'h0010, 8'h14, 32'h38, 32'h08},
    '{20'h40100, 16'h8010, 8'h14, 32'h38, 32'h28},
    '{20'h80000, 16'h0010, 8'h14, 32'h38, 32'h30},
    '{20'h00005, 16'h0015, 8'h20, 32'h4F0000, 32'h4D0000},
    '{20'h00000, 16'h0014, 8'h20, 32'h70000, 32'h0},
    '{20'h0007B, 16'h0015, 8'h20, 32'h4F0000, 32'h430000},
    '{20'h06000, 16'h0013, 8'h20, 32'h3F0000, 32'h60000},
    '{20'h00206, 16'h0007, 8'h20, 32'h3FF, 32'h206},
    '{20'h00206, 16'h0012, 8'h20, 32'h3F0000, 32'h160000},
    '{20'h00002, 16'h0007, 8'h20, 32'h3FF, 32'h002},
    '{20'h00002, 16'h0012, 8'h20, 32'h3F0000, 32'h220000},
    '{20'h20000, 16'h0011, 8'h20, 32'h3F0000, 32'hB0000},
    '{20'h00000, 16'h0016, 8'h20, 32'h3F0000, 32'h2B0000},
    '{20'h00000, 16'h7004, 8'h1C, 32'hFFFFFFFF, 32'hFF000000},
    '{20'h00000, 16'h0004, 8'h1C, 32'hFFFFFFFF, 32'hFF800000}
  };

  always #50 hclk = ~hclk;

  fpmc_datapath_ctrl fpmc_datapath_ctrl_i (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hready_w), .hreadyout(hready_w), .hresp(hresp),
    .hrdata(hrdata), .coprocessor_attention(att), .paused(paused), .integer_long_flag(il));
  fpmc_host_model fpmc_host_model_i (
    .hclk(hclk), .paused(paused), .go(go), .slow(slow), .coprocessor_attention(att));

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // called just after a rising edge; read expectations go to the monitor's queue
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [31:0] m);
    hsel <= 1'b1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {24'h000000, a};
    if (!w)
      notes.push_back('{a, m, d & m});
    do @(posedge hclk); while (hready_w !== 1'b1);
    htrans <= 2'b00;
    if (w)
      hwdata <= d;
    waits = -1;
    do begin
      @(posedge hclk);
      waits++;
    end while (hready_w !== 1'b1);
  endtask

  task automatic pins(input logic e_il, input logic e_pz);
    @(negedge hclk);
    chk("integer_long_flag", {31'h0, e_il}, {31'h0, il});
    chk("paused", {31'h0, e_pz}, {31'h0, paused});
    @(posedge hclk);
  endtask

  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(posedge hclk) begin
    if (rd_dp && hready_w === 1'b1) begin
      nt = notes.pop_front();
      chk($sformatf("reg_%h", nt.addr), nt.exp, hrdata & nt.mask);
      chk("hresp", 32'h0, {31'h0, hresp});
    end
    if (hready_w === 1'b1)
      rd_dp = hsel && htrans[1] && !hwrite;
  end

  initial begin
    repeat (20000) @(posedge hclk);
    error_cnt++;
    stop_test();
  end

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    go = 1'b0;
    slow = 1'b0;
    repeat (4) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b1, 8'h00, 32'h2, 32'h0);
    pins(1'b1, 1'b0);
    xfer(1'b1, 8'h00, 32'h1, 32'h0);
    pins(1'b0, 1'b0);
    for (int k = 0; k < 3; k++) begin
      acc = $random(seed);
      xfer(1'b1, 8'h0C, acc, 32'h0);
      xfer(1'b1, 8'h00, 32'h3, 32'h0);
      xfer(1'b1, 8'h18, ~acc, 32'h0);
      xfer(1'b0, 8'h18, acc, 32'hFFFFFFFF);
      acc = $random(seed);
      xfer(1'b1, 8'h10, acc, 32'h0);
      xfer(1'b1, 8'h00, 32'h17, 32'h0);
      xfer(1'b0, 8'h24, acc, 32'hFFFFFFFF);
      xfer(1'b1, 8'h04, acc, 32'h0);
      xfer(1'b1, 8'h00, 32'h7, 32'h0);
      xfer(1'b0, 8'h20, acc, 32'h3FF);
      xfer(1'b1, 8'h3C, acc, 32'h0);
      xfer(1'b0, 8'h3C, 32'h0, 32'hFFFFFFFF);
    end
    xfer(1'b1, 8'h08, 32'h708, 32'h0);
    foreach (steps[i]) begin
      xfer(1'b1, 8'h04, {12'h000, steps[i].opd}, 32'h0);
      xfer(1'b1, 8'h00, {16'h0000, steps[i].uop}, 32'h0);
      xfer(1'b0, steps[i].addr, steps[i].exp, steps[i].mask);
    end
    // quotient bit offered without divide mode must not reach the register
    xfer(1'b1, 8'h04, 32'h0010_0000, 32'h0);
    xfer(1'b1, 8'h00, 32'h1006, 32'h0);
    xfer(1'b0, 8'h1C, 32'hFF80_0000, 32'hFFFFFFFF);
    xfer(1'b1, 8'h04, 32'h0012_0000, 32'h0);
    xfer(1'b1, 8'h00, 32'h1006, 32'h0);
    xfer(1'b0, 8'h1C, 32'hFF00_0001, 32'hFFFFFFFF);
    xfer(1'b1, 8'h00, 32'h11, 32'h0);
    xfer(1'b1, 8'h00, 32'h6, 32'h0);
    xfer(1'b0, 8'h1C, 32'hF800_0008, 32'hFFFFFFFF);
    xfer(1'b1, 8'h00, 32'h5, 32'h0);
    xfer(1'b0, 8'h1C, 32'h0, 32'hFFFFFFFF);
    xfer(1'b1, 8'h00, 32'h8, 32'h0);
    xfer(1'b0, 8'h14, 32'h0, 32'hF00);
    xfer(1'b1, 8'h00, 32'h0, 32'h0);
    xfer(1'b1, 8'h00, 32'h0, 32'h0);
    w_norm = waits;
    xfer(1'b1, 8'h00, 32'h100, 32'h0);
    xfer(1'b1, 8'h00, 32'h0, 32'h0);
    chk("long_state_waits", 32'(w_norm + 1), 32'(waits));
    for (int k = 0; k < 2; k++) begin
      slow <= k[0];
      xfer(1'b1, 8'h00, 32'h18, 32'h0);
      pins(1'b0, 1'b1);
      xfer(1'b1, 8'h00, 32'h2, 32'h0);
      pins(1'b0, 1'b1);
      go <= 1'b1;
      n = 0;
      while (paused !== 1'b0 && n < 60) begin
        @(posedge hclk);
        n++;
      end
      go <= 1'b0;
      chk("resume_bound", 32'h1, {31'h0, n < 60});
      pins(1'b0, 1'b0);
      repeat (12) @(posedge hclk);
    end
    repeat (2) @(posedge hclk);
    chk("notes_left", 32'h0, 32'(notes.size()));
    stop_test();
  end
endmodule // fpmc_datapath_ctrl_tb
`default_nettype wire

// ---- dv/fpmc_host_model.sv ----
// host model that wakes a paused coprocessor with attention
`timescale 1ns/1ns
`default_nettype none
module fpmc_host_model (
  input  wire logic hclk,
  input  wire logic paused,
  input  wire logic go,
  input  wire logic slow,
  output logic      coprocessor_attention = 1'b0
);
  // pulse is held long enough for the three-flop synchroniser, then the pin idles low
  always begin
    @(posedge hclk);
    if (go && paused) begin
      repeat (slow ? 20 : 2) @(posedge hclk);
      coprocessor_attention <= 1'b1;
      repeat (8) @(posedge hclk);
      coprocessor_attention <= 1'b0;
      repeat (4) @(posedge hclk);
    end
  end
endmodule // fpmc_host_model
`default_nettype wire
